// ### pkg/gafm_pkg.sv
package gafm_pkg;
    // pin indices inside the block: local index k serves general purpose pin 3 + k
    localparam int          NUM_PINS      = 6;
    localparam int          PIN_FIRST     = 3;
    localparam int          P3            = 0;
    localparam int          P4            = 1;
    localparam int          P5            = 2;
    localparam int          P6            = 3;
    localparam int          P7            = 4;
    localparam int          P8            = 5;
    localparam int          SEL_W         = 2;
    localparam int          NUM_FAILOVER  = 4;
    localparam int          NUM_STATUS    = 6;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;

    // function select codes; the spare code decodes as general purpose
    localparam logic [1:0]  SEL_GP        = 2'h0;
    localparam logic [1:0]  SEL_ALT1      = 2'h1;
    localparam logic [1:0]  SEL_ALT2      = 2'h2;

    // register byte addresses
    localparam logic [7:0]  ADDR_FUNC_SEL = 8'h00;
    localparam logic [7:0]  ADDR_GP_OUT   = 8'h04;
    localparam logic [7:0]  ADDR_GP_OE    = 8'h08;
    localparam logic [7:0]  ADDR_PIN_IN   = 8'h0C;
    localparam logic [7:0]  ADDR_FO_EN    = 8'h10;
    localparam logic [7:0]  ADDR_STATUS   = 8'h14;
    localparam logic [7:0]  ADDR_MASK     = 8'h18;
    localparam logic [7:0]  ADDR_STRAPS   = 8'h1C;

    // status and mask bit positions; failover events sit in bits 3:0
    localparam int          ST_PART3_RST  = 4;
    localparam int          ST_EXP_INT    = 5;

    // strap register layout
    localparam int          STRAP_STK_LSB = 0;
    localparam int          STRAP_CLK_LSB = 3;
    localparam int          STRAP_FSEL    = 5;
    localparam int          STRAP_MHZ_LSB = 8;

    localparam logic [7:0]  REFCLK_MHZ_SEL0 = 8'h64;
    localparam logic [7:0]  REFCLK_MHZ_SEL1 = 8'h7D;

    // reset values
    localparam logic [11:0] FUNC_SEL_RST  = 12'h000;
    localparam logic [5:0]  GP_OUT_RST    = 6'h00;
    localparam logic [5:0]  GP_OE_RST     = 6'h00;
    localparam logic [3:0]  FO_EN_RST     = 4'h0;
    localparam logic [5:0]  MASK_RST      = 6'h00;
endpackage : gafm_pkg

// ### rtl/gafm_pin_cell.sv
module gafm_pin_cell (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic [1:0] i_sel,
    input  wire logic       i_gp_out,
    input  wire logic       i_gp_oe,
    input  wire logic       i_alt1_out,
    input  wire logic       i_alt1_oe,
    input  wire logic       i_alt2_out,
    input  wire logic       i_alt2_oe,
    output logic            o_pad_out,
    output logic            o_pad_oe
);
    logic pad_out_d;
    logic pad_oe_d;

    always_comb begin
        case (i_sel)
            gafm_pkg::SEL_ALT1: begin
                pad_out_d = i_alt1_out;
                pad_oe_d  = i_alt1_oe;
            end
            gafm_pkg::SEL_ALT2: begin
                pad_out_d = i_alt2_out;
                pad_oe_d  = i_alt2_oe;
            end
            default: begin
                pad_out_d = i_gp_out;
                pad_oe_d  = i_gp_oe;
            end
        endcase
    end

    // pad registered so the pin never glitches while the select changes
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pad_out <= 1'b0;
            o_pad_oe  <= 1'b0;
        end else begin
            o_pad_out <= pad_out_d;
            o_pad_oe  <= pad_oe_d;
        end
    end
endmodule : gafm_pin_cell

// ### rtl/gafm_mux_top.sv
// Notes on behaviour
// - pins 3-8 are GPIO or an alternate function
// - pin 3 alt1 low requests partition 3 reset
// - pin 3 alt2 drives port 4 link active
// - failover input change raises event if enabled
// - pin 4 failover 0, or port 0 link up
// - pin 5 alt1 drives hot-plug event out
// - pin 5 alt2 drives port 0 link active
// - pin 6 is failover 1 or failover 3
// - pin 7 failover 2, or port 8 link up
// - pin 8 alt1 takes expander interrupt, low active
// - pin 8 alt2 drives port 8 link active
// - three stack configuration straps sampled, one each
// - two-bit strap selects port clocking mode
// - frequency select: 0 is 100 MHz, 1 is 125
module gafm_mux_top #(
    parameter int NUM_PINS     = gafm_pkg::NUM_PINS,
    parameter int NUM_FAILOVER = gafm_pkg::NUM_FAILOVER
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset_n,
    input  wire logic [7:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [31:0]             o_rdata,
    output logic                         o_irq,
    input  wire logic [NUM_PINS-1:0]     i_gpio_in,
    output logic      [NUM_PINS-1:0]     o_gpio_out,
    output logic      [NUM_PINS-1:0]     o_gpio_oe,
    input  wire logic                    i_port4_link_active,
    input  wire logic                    i_port0_link_up,
    input  wire logic                    i_port0_link_active,
    input  wire logic                    i_port8_link_up,
    input  wire logic                    i_port8_link_active,
    input  wire logic                    i_hotplug_event,
    output logic                         o_partition3_reset_request,
    output logic                         o_expander_interrupt_in,
    output logic      [NUM_FAILOVER-1:0] o_failover_event,
    input  wire logic                    i_stack0_config_strap,
    input  wire logic                    i_stack1_config_strap,
    input  wire logic                    i_stack2_config_strap,
    input  wire logic [1:0]              i_port_clocking_mode_strap,
    input  wire logic                    i_refclk_frequency_select,
    output logic      [2:0]              o_stack_config,
    output logic      [1:0]              o_port_clocking_mode,
    output logic                         o_refclk_is_125mhz,
    output logic      [7:0]              o_refclk_freq_mhz
);
    logic [2*NUM_PINS-1:0]        func_sel_q;
    logic [NUM_PINS-1:0]          gp_out_q;
    logic [NUM_PINS-1:0]          gp_oe_q;
    logic [NUM_FAILOVER-1:0]      fo_en_q;
    logic [gafm_pkg::NUM_STATUS-1:0] mask_q;
    logic [gafm_pkg::NUM_STATUS-1:0] status_q;
    logic [gafm_pkg::NUM_STATUS-1:0] status_set;
    logic [NUM_PINS-1:0]          pin_prev_q;
    logic                         prev_valid_q;
    logic [NUM_FAILOVER-1:0]      fo_mode;
    logic [NUM_FAILOVER-1:0]      fo_pin;
    logic [NUM_FAILOVER-1:0]      fo_prev;
    logic [NUM_FAILOVER-1:0]      fo_change;
    logic                         part3_req;
    logic                         exp_req;
    logic                         strap_done_q;
    logic [31:0]                  rd_val;
    logic [NUM_PINS-1:0]          alt1_out;
    logic [NUM_PINS-1:0]          alt1_oe;
    logic [NUM_PINS-1:0]          alt2_out;
    logic [NUM_PINS-1:0]          alt2_oe;

    function automatic logic is_func(input logic [2*gafm_pkg::NUM_PINS-1:0] sel,
                                     input int pin, input logic [1:0] code);
        is_func = (sel[2*pin +: 2] == code);
    endfunction : is_func

    // register writes
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            func_sel_q <= gafm_pkg::FUNC_SEL_RST;
            gp_out_q   <= gafm_pkg::GP_OUT_RST;
            gp_oe_q    <= gafm_pkg::GP_OE_RST;
            fo_en_q    <= gafm_pkg::FO_EN_RST;
            mask_q     <= gafm_pkg::MASK_RST;
        end else if (i_wr) begin
            case (i_addr)
                gafm_pkg::ADDR_FUNC_SEL: func_sel_q <= i_wdata[2*NUM_PINS-1:0];
                gafm_pkg::ADDR_GP_OUT:   gp_out_q   <= i_wdata[NUM_PINS-1:0];
                gafm_pkg::ADDR_GP_OE:    gp_oe_q    <= i_wdata[NUM_PINS-1:0];
                gafm_pkg::ADDR_FO_EN:    fo_en_q    <= i_wdata[NUM_FAILOVER-1:0];
                gafm_pkg::ADDR_MASK:     mask_q     <= i_wdata[gafm_pkg::NUM_STATUS-1:0];
                default: begin
                end
            endcase
        end
    end

    // alternate function outputs; status pins are active low on the board
    always_comb begin
        alt1_out          = '0;
        alt1_oe           = '0;
        alt2_out          = '0;
        alt2_oe           = '0;
        alt2_out[gafm_pkg::P3] = ~i_port4_link_active;
        alt2_oe[gafm_pkg::P3]  = 1'b1;
        alt2_out[gafm_pkg::P4] = ~i_port0_link_up;
        alt2_oe[gafm_pkg::P4]  = 1'b1;
        alt1_out[gafm_pkg::P5] = ~i_hotplug_event;
        alt1_oe[gafm_pkg::P5]  = 1'b1;
        alt2_out[gafm_pkg::P5] = ~i_port0_link_active;
        alt2_oe[gafm_pkg::P5]  = 1'b1;
        alt2_out[gafm_pkg::P7] = ~i_port8_link_up;
        alt2_oe[gafm_pkg::P7]  = 1'b1;
        alt2_out[gafm_pkg::P8] = ~i_port8_link_active;
        alt2_oe[gafm_pkg::P8]  = 1'b1;
    end

    for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
        gafm_pin_cell u_cell (
            .i_clk_sys  (i_clk_sys),
            .i_reset_n  (i_reset_n),
            .i_sel      (func_sel_q[2*k +: 2]),
            .i_gp_out   (gp_out_q[k]),
            .i_gp_oe    (gp_oe_q[k]),
            .i_alt1_out (alt1_out[k]),
            .i_alt1_oe  (alt1_oe[k]),
            .i_alt2_out (alt2_out[k]),
            .i_alt2_oe  (alt2_oe[k]),
            .o_pad_out  (o_gpio_out[k]),
            .o_pad_oe   (o_gpio_oe[k])
        );
    end

    // failover inputs: which pin and which select feed each one
    always_comb begin
        fo_mode[0] = is_func(func_sel_q, gafm_pkg::P4, gafm_pkg::SEL_ALT1);
        fo_pin[0]  = i_gpio_in[gafm_pkg::P4];
        fo_prev[0] = pin_prev_q[gafm_pkg::P4];
        fo_mode[1] = is_func(func_sel_q, gafm_pkg::P6, gafm_pkg::SEL_ALT1);
        fo_pin[1]  = i_gpio_in[gafm_pkg::P6];
        fo_prev[1] = pin_prev_q[gafm_pkg::P6];
        fo_mode[2] = is_func(func_sel_q, gafm_pkg::P7, gafm_pkg::SEL_ALT1);
        fo_pin[2]  = i_gpio_in[gafm_pkg::P7];
        fo_prev[2] = pin_prev_q[gafm_pkg::P7];
        fo_mode[3] = is_func(func_sel_q, gafm_pkg::P6, gafm_pkg::SEL_ALT2);
        fo_pin[3]  = i_gpio_in[gafm_pkg::P6];
        fo_prev[3] = pin_prev_q[gafm_pkg::P6];
        // no history in the first cycle after reset, so no false change
        fo_change  = (fo_pin ^ fo_prev) & {NUM_FAILOVER{prev_valid_q}};
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_prev_q   <= '0;
            prev_valid_q <= 1'b0;
        end else begin
            pin_prev_q   <= i_gpio_in;
            prev_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_failover_event <= '0;
        end else begin
            o_failover_event <= fo_change & fo_mode & fo_en_q;
        end
    end

    // active-low requests on pins 3 and 8
    assign part3_req = is_func(func_sel_q, gafm_pkg::P3, gafm_pkg::SEL_ALT1)
                       & ~i_gpio_in[gafm_pkg::P3];
    assign exp_req   = is_func(func_sel_q, gafm_pkg::P8, gafm_pkg::SEL_ALT1)
                       & ~i_gpio_in[gafm_pkg::P8];

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_partition3_reset_request <= 1'b0;
            o_expander_interrupt_in    <= 1'b0;
        end else begin
            o_partition3_reset_request <= part3_req;
            o_expander_interrupt_in    <= exp_req;
        end
    end

    // sticky status; a read clears, but a new event in that cycle survives
    always_comb begin
        status_set = '0;
        status_set[NUM_FAILOVER-1:0]      = fo_change & fo_mode & fo_en_q;
        status_set[gafm_pkg::ST_PART3_RST] = part3_req;
        status_set[gafm_pkg::ST_EXP_INT]   = exp_req;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_q <= '0;
        end else if (i_rd && i_addr == gafm_pkg::ADDR_STATUS) begin
            status_q <= status_set;
        end else begin
            status_q <= status_q | status_set;
        end
    end

    assign o_irq = |(status_q & mask_q);

    // straps are caught once, on the first edge after reset release
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_done_q         <= 1'b0;
            o_stack_config       <= 3'h0;
            o_port_clocking_mode <= 2'h0;
            o_refclk_is_125mhz   <= 1'b0;
            o_refclk_freq_mhz    <= gafm_pkg::REFCLK_MHZ_SEL0;
        end else if (!strap_done_q) begin
            strap_done_q         <= 1'b1;
            o_stack_config       <= {i_stack2_config_strap, i_stack1_config_strap,
                                     i_stack0_config_strap};
            o_port_clocking_mode <= i_port_clocking_mode_strap;
            o_refclk_is_125mhz   <= i_refclk_frequency_select;
            o_refclk_freq_mhz    <= i_refclk_frequency_select ? gafm_pkg::REFCLK_MHZ_SEL1
                                                              : gafm_pkg::REFCLK_MHZ_SEL0;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        case (i_addr)
            gafm_pkg::ADDR_FUNC_SEL: rd_val[2*NUM_PINS-1:0] = func_sel_q;
            gafm_pkg::ADDR_GP_OUT:   rd_val[NUM_PINS-1:0]   = gp_out_q;
            gafm_pkg::ADDR_GP_OE:    rd_val[NUM_PINS-1:0]   = gp_oe_q;
            gafm_pkg::ADDR_PIN_IN:   rd_val[NUM_PINS-1:0]   = i_gpio_in;
            gafm_pkg::ADDR_FO_EN:    rd_val[NUM_FAILOVER-1:0] = fo_en_q;
            gafm_pkg::ADDR_STATUS:   rd_val[gafm_pkg::NUM_STATUS-1:0] = status_q;
            gafm_pkg::ADDR_MASK:     rd_val[gafm_pkg::NUM_STATUS-1:0] = mask_q;
            gafm_pkg::ADDR_STRAPS: begin
                rd_val[gafm_pkg::STRAP_STK_LSB +: 3] = o_stack_config;
                rd_val[gafm_pkg::STRAP_CLK_LSB +: 2] = o_port_clocking_mode;
                rd_val[gafm_pkg::STRAP_FSEL]         = o_refclk_is_125mhz;
                rd_val[gafm_pkg::STRAP_MHZ_LSB +: 8] = o_refclk_freq_mhz;
            end
            default: begin
            end
        endcase
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_rd ? rd_val : 32'h0000_0000;
        end
    end

    property p_gp_follow;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (func_sel_q[1:0] == gafm_pkg::SEL_GP) |=>
            (o_gpio_out[0] == $past(gp_out_q[0]) && o_gpio_oe[0] == $past(gp_oe_q[0]));
    endproperty
    a_gp_follow: assert property (p_gp_follow) else $error("pin 3 not following gpio registers");

    property p_part3_req;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (is_func(func_sel_q, gafm_pkg::P3, gafm_pkg::SEL_ALT1) && !i_gpio_in[gafm_pkg::P3])
            |=> o_partition3_reset_request && status_q[gafm_pkg::ST_PART3_RST];
    endproperty
    a_part3_req: assert property (p_part3_req) else $error("partition 3 reset request missed");

    property p_pin3_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P3, gafm_pkg::SEL_ALT2)
            |=> o_gpio_oe[gafm_pkg::P3] && (o_gpio_out[gafm_pkg::P3] == !$past(i_port4_link_active));
    endproperty
    a_pin3_alt2: assert property (p_pin3_alt2) else $error("pin 3 not showing port 4 active");

    property p_fo_event;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (fo_mode[0] && fo_en_q[0] && prev_valid_q && (fo_pin[0] != fo_prev[0]))
            |=> o_failover_event[0] ##1 (!o_failover_event[0] || $past(fo_change[0]));
    endproperty
    a_fo_event: assert property (p_fo_event) else $error("failover 0 event missing");

    property p_fo_disabled;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !fo_en_q[3] |=> !o_failover_event[3];
    endproperty
    a_fo_disabled: assert property (p_fo_disabled) else $error("failover 3 event while disabled");

    property p_fo_pin6_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (is_func(func_sel_q, gafm_pkg::P6, gafm_pkg::SEL_ALT2) && fo_en_q[3] && prev_valid_q &&
         $changed(i_gpio_in[gafm_pkg::P6])) |=> o_failover_event[3] && !o_failover_event[1];
    endproperty
    a_fo_pin6_alt2: assert property (p_fo_pin6_alt2) else $error("pin 6 alt2 not failover 3");

    property p_pin5_alt1;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P5, gafm_pkg::SEL_ALT1)
            |=> o_gpio_oe[gafm_pkg::P5] && (o_gpio_out[gafm_pkg::P5] == !$past(i_hotplug_event));
    endproperty
    a_pin5_alt1: assert property (p_pin5_alt1) else $error("pin 5 not showing hot-plug event");

    property p_pin8_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P8, gafm_pkg::SEL_ALT2)
            |=> o_gpio_oe[gafm_pkg::P8] && (o_gpio_out[gafm_pkg::P8] == !$past(i_port8_link_active));
    endproperty
    a_pin8_alt2: assert property (p_pin8_alt2) else $error("pin 8 not showing port 8 active");

    property p_pin4_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P4, gafm_pkg::SEL_ALT2)
            |=> o_gpio_oe[gafm_pkg::P4] && (o_gpio_out[gafm_pkg::P4] == !$past(i_port0_link_up));
    endproperty
    a_pin4_alt2: assert property (p_pin4_alt2) else $error("pin 4 not showing port 0 link up");

    property p_pin5_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P5, gafm_pkg::SEL_ALT2)
            |=> o_gpio_oe[gafm_pkg::P5] && (o_gpio_out[gafm_pkg::P5] == !$past(i_port0_link_active));
    endproperty
    a_pin5_alt2: assert property (p_pin5_alt2) else $error("pin 5 not showing port 0 active");

    property p_pin7_alt2;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        is_func(func_sel_q, gafm_pkg::P7, gafm_pkg::SEL_ALT2)
            |=> o_gpio_oe[gafm_pkg::P7] && (o_gpio_out[gafm_pkg::P7] == !$past(i_port8_link_up));
    endproperty
    a_pin7_alt2: assert property (p_pin7_alt2) else $error("pin 7 not showing port 8 link up");

    property p_exp_int;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !is_func(func_sel_q, gafm_pkg::P8, gafm_pkg::SEL_ALT1) |=> !o_expander_interrupt_in;
    endproperty
    a_exp_int: assert property (p_exp_int) else $error("expander interrupt outside its function");

    property p_strap_hold;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        strap_done_q |=> $stable(o_stack_config) && $stable(o_port_clocking_mode) &&
                         $stable(o_refclk_freq_mhz);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap outputs changed after capture");

    property p_refclk_mhz;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        strap_done_q |-> (o_refclk_freq_mhz == (o_refclk_is_125mhz ? gafm_pkg::REFCLK_MHZ_SEL1
                                                                    : gafm_pkg::REFCLK_MHZ_SEL0));
    endproperty
    a_refclk_mhz: assert property (p_refclk_mhz) else $error("reference clock frequency mismatch");
endmodule : gafm_mux_top

// ### test/gafm_board_model.sv
module gafm_board_model (
    input  wire logic [5:0] i_pad_out,
    input  wire logic [5:0] i_pad_oe,
    input  wire logic [5:0] i_drive_en,
    input  wire logic [5:0] i_drive_val,
    output logic      [5:0] o_pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven lines settle at the board pull-up, the idle level of every active-low input
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            if (i_pad_oe[k]) o_pad_in[k] = i_pad_out[k];
            else if (i_drive_en[k]) o_pad_in[k] = i_drive_val[k];
            else o_pad_in[k] = 1'b1;
        end
    end
endmodule : gafm_board_model

// ### test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, bus_wr, bus_rd, hot, fsel;
    logic [7:0]  addr, mhz;
    logic [31:0] wdata, rdata, seed, d;
    logic [5:0]  gin, gout, goe, bval, go_r, goe_r;
    logic [4:0]  lk;
    logic [3:0]  fo_ev;
    logic [2:0]  stk, stk_o;
    logic [1:0]  cm, cm_o, e;
    logic        req, xint, irq, is125;
    int          bad_count, n_tests, cnt;
    int          fo_pin[4]  = '{1, 3, 4, 3};
    logic [1:0]  fo_code[4] = '{2'h1, 2'h1, 2'h1, 2'h2};

    gafm_mux_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr),
        .i_rd(bus_rd), .o_rdata(rdata), .o_irq(irq), .i_gpio_in(gin), .o_gpio_out(gout), .o_gpio_oe(goe),
        .i_port4_link_active(lk[0]), .i_port0_link_up(lk[1]), .i_port0_link_active(lk[2]),
        .i_port8_link_up(lk[3]), .i_port8_link_active(lk[4]), .i_hotplug_event(hot),
        .o_partition3_reset_request(req), .o_expander_interrupt_in(xint), .o_failover_event(fo_ev),
        .i_stack0_config_strap(stk[0]), .i_stack1_config_strap(stk[1]), .i_stack2_config_strap(stk[2]),
        .i_port_clocking_mode_strap(cm), .i_refclk_frequency_select(fsel), .o_stack_config(stk_o),
        .o_port_clocking_mode(cm_o), .o_refclk_is_125mhz(is125), .o_refclk_freq_mhz(mhz));
    gafm_board_model board (.i_pad_out(gout), .i_pad_oe(goe), .i_drive_en(6'h3F), .i_drive_val(bval),
        .o_pad_in(gin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    // expected {oe, out} of local pin k under select code c
    function automatic logic [1:0] exp_pad(input int k, input logic [1:0] c);
        if (c == 2'h1) return (k == 2) ? {1'b1, ~hot} : 2'h0;
        if (c == 2'h2) begin
            case (k)
                0: return {1'b1, ~lk[0]};
                1: return {1'b1, ~lk[1]};
                2: return {1'b1, ~lk[2]};
                4: return {1'b1, ~lk[3]};
                5: return {1'b1, ~lk[4]};
                default: return 2'h0;
            endcase
        end
        return {goe_r[k], go_r[k]};
    endfunction : exp_pad

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd

    initial begin
        #1_000_000;
        bad_count++;
        close_out();
    end

    initial begin
        {rst_n, bus_wr, bus_rd, hot, fsel, addr, wdata, lk, stk, cm} = '0;
        bval = 6'h3F;
        seed = 32'h9ECDB442;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            fsel <= r[0];
            {stk, cm} <= 5'(rnd());
            repeat (12) @(posedge clk);
            rst_n <= 1'b1;
            repeat (2) @(posedge clk);
            #1 chk("stack", stk_o, stk);
            chk("clkmode", cm_o, cm);
            chk("is125", is125, fsel);
            chk("mhz", mhz, fsel ? 8'h7D : 8'h64);
            chk("oe after reset", goe, 6'h00);
            reg_rd(gafm_pkg::ADDR_FUNC_SEL, d);
            chk("func_sel reset", d, 32'h0);
            reg_rd(8'h20, d);
            chk("unmapped", d, 32'h0);
            reg_wr(gafm_pkg::ADDR_STRAPS, 32'hFFFFFFFF);
            reg_rd(gafm_pkg::ADDR_STRAPS, d);
            chk("straps", d, {16'h0, fsel ? 8'h7D : 8'h64, 2'h0, fsel, cm, stk});
        end
        repeat (8) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                {hot, lk} <= 6'(rnd());
                go_r = 6'(rnd());
                goe_r = 6'(rnd());
                reg_wr(gafm_pkg::ADDR_GP_OUT, {26'h0, go_r});
                reg_wr(gafm_pkg::ADDR_GP_OE, {26'h0, goe_r});
                reg_wr(gafm_pkg::ADDR_FUNC_SEL, {20'h0, {6{c[1:0]}}});
                repeat (3) @(posedge clk);
                #1;
                for (int k = 0; k < 6; k++) begin
                    e = exp_pad(k, c[1:0]);
                    chk("pad oe", goe[k], e[1]);
                    chk("pad out", gout[k] & e[1], e[0] & e[1]);
                end
            end
        end
        reg_wr(gafm_pkg::ADDR_GP_OE, 32'h0);
        reg_wr(gafm_pkg::ADDR_MASK, 32'h0F);
        for (int n = 0; n < 4; n++) begin
            for (int en = 0; en < 2; en++) begin
                reg_wr(gafm_pkg::ADDR_FO_EN, 32'h0);
                reg_wr(gafm_pkg::ADDR_FUNC_SEL, {20'h0, {6{fo_code[n]}}});
                repeat (3) @(posedge clk);
                reg_rd(gafm_pkg::ADDR_STATUS, d);
                reg_wr(gafm_pkg::ADDR_FO_EN, en ? (32'h1 << n) : 32'h0);
                @(posedge clk);
                bval[fo_pin[n]] <= ~bval[fo_pin[n]];
                cnt = 0;
                repeat (4) begin
                    @(posedge clk);
                    #1 cnt += (fo_ev == 4'(en << n)) && (fo_ev != 4'h0);
                    chk("other events", fo_ev & ~(4'h1 << n), 4'h0);
                end
                chk("event count", cnt, en);
                chk("irq set", irq, en[0]);
                reg_rd(gafm_pkg::ADDR_STATUS, d);
                chk("status", d[5:0], 6'(en << n));
                chk("irq cleared", irq, 1'b0);
            end
        end
        reg_wr(gafm_pkg::ADDR_MASK, 32'h30);
        for (int s = 0; s < 2; s++) begin
            reg_wr(gafm_pkg::ADDR_FUNC_SEL, s ? 32'h401 : 32'h0);
            repeat (3) @(posedge clk);
            reg_rd(gafm_pkg::ADDR_STATUS, d);
            @(posedge clk);
            bval[0] <= 1'b0;
            bval[5] <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk("part3 req", req, s);
            chk("expander int", xint, s);
            chk("irq level", irq, s);
            reg_rd(gafm_pkg::ADDR_PIN_IN, d);
            chk("pin in", d, {26'h0, bval});
            @(posedge clk);
            bval[0] <= 1'b1;
            bval[5] <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk("part3 idle", req, 1'b0);
            chk("expander idle", xint, 1'b0);
            reg_rd(gafm_pkg::ADDR_STATUS, d);
            chk("status sticky", d[5:4], s ? 2'h3 : 2'h0);
        end
        close_out();
    end
endmodule : testbench
